// ---- cbcc_consts.svh ----
// Constants of the breaker command control block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef CBCC_CONSTS_SVH
`define CBCC_CONSTS_SVH
`define CBCC_CLK_NS       10
`define CBCC_MS_NS        1000000
`define CBCC_CYC_PER_MS   (`CBCC_MS_NS / `CBCC_CLK_NS)
// Register byte offsets
`define CBCC_OFS_CMD      5'h00
`define CBCC_OFS_PULSE    5'h04
`define CBCC_OFS_SYNCHK   5'h08
`define CBCC_OFS_SYNSW    5'h0C
`define CBCC_OFS_FILTER   5'h10
`define CBCC_OFS_STATUS   5'h14
// Command register bits
`define CBCC_CMD_OPEN_LOC 0
`define CBCC_CMD_CLS_LOC  1
`define CBCC_CMD_OPEN_REM 2
`define CBCC_CMD_CLS_REM  3
`define CBCC_CMD_CLR_UNI  4
// Settings in ms: reset value, least, most
`define CBCC_PULSE_RST    16'h012C
`define CBCC_PULSE_MIN    16'h0032
`define CBCC_PULSE_MAX    16'h03E8
`define CBCC_SYNCHK_RST   16'h03E8
`define CBCC_SYNCHK_MIN   16'h000A
`define CBCC_SYNCHK_MAX   16'h1388
`define CBCC_SYNSW_RST    16'h0000
`define CBCC_SYNSW_MAX    16'hEA60
`define CBCC_FILTER_RST   16'h0014
`define CBCC_FILTER_MIN   16'h0001
`define CBCC_FILTER_MAX   16'h01F4
// Fixed times in ms
`define CBCC_HOLD_MIN_MS  16'h0064
`define CBCC_OPER_MS      16'h0096
`endif

// ---- cbcc_pkg.sv ----
// Types of the breaker command control block.
// Assumes nothing of its surroundings.
package cbcc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_OPEN  = 2'b01,
    ST_WAIT  = 2'b10,
    ST_CLOSE = 2'b11
  } cbcc_state_e;
endpackage

// ---- cbcc_tick_if.sv ----
// Millisecond tick carried from the divider to the control logic.
// Assumes both ends on clk_sys.
`timescale 1ns/1ps
interface cbcc_tick_if;
  logic msTick;
  modport src (output msTick);
  modport snk (input msTick);
endinterface

// ---- cbcc_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs asynchronous to clk_sys.
`timescale 1ns/1ps
module cbcc_sync #(
  parameter int unsigned W = 9
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinSync
);
  if (W < 1) begin : g_chk
    $error("cbcc_sync: W must be at least 1");
  end
  logic [W-1:0] meta_r;
  // First flop feeds only the second one
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        meta_r[i]  <= 1'b0;
        pinSync[i] <= 1'b0;
      end else begin
        meta_r[i]  <= pinIn[i];
        pinSync[i] <= meta_r[i];
      end
    end
  end
endmodule

// ---- cbcc_ms_tick.sv ----
// Divider giving a one-cycle enable once per millisecond.
// Assumes CYC_PER_MS clk_sys cycles make one ms.
`timescale 1ns/1ps
module cbcc_ms_tick #(
  parameter int unsigned CYC_PER_MS = 100000
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  cbcc_tick_if.src  tick
);
  localparam int unsigned CW = $clog2(CYC_PER_MS);
  if (CYC_PER_MS < 2) begin : g_chk
    $error("cbcc_ms_tick: CYC_PER_MS must be at least 2");
  end
  logic [CW-1:0] cnt_r;
  // Free-running count, tick on wrap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= '0;
      tick.msTick <= 1'b0;
    end else if (cnt_r == CW'(CYC_PER_MS - 1)) begin
      cnt_r       <= '0;
      tick.msTick <= 1'b1;
    end else begin
      cnt_r       <= cnt_r + 1'b1;
      tick.msTick <= 1'b0;
    end
  end
endmodule

// ---- cbcc_top.sv ----
// Breaker command control: permits, command pulses, position filter.
// Assumes pins asynchronous, Avalon-MM master on clk_sys.
// How it works
// RULE_01: Local commands need the local permit
// RULE_02: Remote commands need the remote permit
// RULE_03: Close issues only with sync permit
// RULE_04: Outside ties sync permit true if unused
// RULE_05: Open issues only with open interlock
// RULE_06: Close issues only with close interlock
// RULE_07: Inhibit suppresses all command pulses
// RULE_08: Breaker drives open and closed status
// RULE_09: External flag only feeds unintended check
// RULE_10: Open pulse lasts the pulse setting
// RULE_11: Close pulse lasts the pulse setting
// RULE_12: Sync missing too long fires switch trigger
// RULE_13: Each operation gives 150 ms pulse
// RULE_14: Change without command flags unintended
// RULE_15: Filtered closed position from closed status
// RULE_16: Filtered open position from open status
// RULE_17: Pulse setting 50 to 1000 ms, 300
// RULE_18: Confirmed switching ends pulse after 100 ms
// RULE_19: Zero switch wait never fires trigger
// RULE_20: All permits must hold at once; close checks local or remote permit only when written, not when sync arrives
// RULE_21: Position follows after stable exclusive interval
// RULE_22: Filtered position change is an operation
`timescale 1ns/1ps
`include "cbcc_consts.svh"
module cbcc_top #(
  parameter int unsigned CYC_PER_MS = `CBCC_CYC_PER_MS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        localPermit,
  input  wire logic        remotePermit,
  input  wire logic        syncPermit,
  input  wire logic        openInterlockPermit,
  input  wire logic        closeInterlockPermit,
  input  wire logic        controlInhibit,
  input  wire logic        breakerOpenStatus,
  input  wire logic        breakerClosedStatus,
  input  wire logic        externalCommandSeen,
  output logic             openCommandPulse,
  output logic             closeCommandPulse,
  output logic             syncSwitchTrigger,
  output logic             operationPulse,
  output logic             unintendedSwitchingFlag,
  output logic             positionOpen,
  output logic             positionClosed
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and ms tick
  logic [8:0] pinS;
  logic       locS, remS, syncS, openIlkS, closeIlkS;
  logic       inhibitS, openS, closedS, extS;
  cbcc_tick_if tickIf ();

  cbcc_sync #(.W(9)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   ({externalCommandSeen, breakerClosedStatus,
               breakerOpenStatus, controlInhibit, closeInterlockPermit,
               openInterlockPermit, syncPermit, remotePermit,
               localPermit}),
    .pinSync (pinS)
  );

  cbcc_ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (tickIf.src)
  );

  // Unpack synchronised pins
  assign {extS, closedS, openS, inhibitS, closeIlkS,
          openIlkS, syncS, remS, locS} = pinS;

  ////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then answer
  logic        avsWait_r;
  logic        busWr;
  logic        cmdWr;
  logic        wordWr;
  logic [15:0] wd16;
  logic [15:0] pulseLen_r;
  logic [15:0] synChk_r;
  logic [15:0] synSw_r;
  logic [15:0] filter_r;
  logic [31:0] rdMux;

  // Waitrequest drops for one cycle per request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avsWait_r <= 1'b1;
    end else if ((avs_read || avs_write) && avsWait_r) begin
      avsWait_r <= 1'b0;
    end else begin
      avsWait_r <= 1'b1;
    end
  end
  assign avs_waitrequest = avsWait_r;

  assign busWr  = avs_write && !avsWait_r;
  assign cmdWr  = busWr && (avs_address == `CBCC_OFS_CMD) && avs_byteenable[0];
  assign wordWr = busWr && (avs_byteenable[1:0] == 2'b11);
  assign wd16   = avs_writedata[15:0];

  // Settings; out-of-range writes keep the old value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulseLen_r <= `CBCC_PULSE_RST;
      synChk_r   <= `CBCC_SYNCHK_RST;
      synSw_r    <= `CBCC_SYNSW_RST;
      filter_r   <= `CBCC_FILTER_RST;
    end else if (wordWr) begin
      if (avs_address == `CBCC_OFS_PULSE && wd16 >= `CBCC_PULSE_MIN
          && wd16 <= `CBCC_PULSE_MAX) begin
        pulseLen_r <= wd16; // [RULE_17]
      end
      if (avs_address == `CBCC_OFS_SYNCHK && wd16 >= `CBCC_SYNCHK_MIN
          && wd16 <= `CBCC_SYNCHK_MAX) begin
        synChk_r <= wd16;
      end
      if (avs_address == `CBCC_OFS_SYNSW && wd16 <= `CBCC_SYNSW_MAX) begin
        synSw_r <= wd16;
      end
      if (avs_address == `CBCC_OFS_FILTER && wd16 >= `CBCC_FILTER_MIN
          && wd16 <= `CBCC_FILTER_MAX) begin
        filter_r <= wd16;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command acceptance
  logic openReq, closeReq, openGo, closeGo;

  // Panel bits obey local permit, station bits remote permit
  assign openReq  = (cmdWr && avs_writedata[`CBCC_CMD_OPEN_LOC] && locS)
                 || (cmdWr && avs_writedata[`CBCC_CMD_OPEN_REM] && remS); // [RULE_01] [RULE_02]
  assign closeReq = (cmdWr && avs_writedata[`CBCC_CMD_CLS_LOC] && locS)
                 || (cmdWr && avs_writedata[`CBCC_CMD_CLS_REM] && remS); // [RULE_01] [RULE_02]
  // Open wins when both are written together
  assign openGo  = openReq && openIlkS && !inhibitS; // [RULE_05] [RULE_07] [RULE_20]
  assign closeGo = closeReq && !openReq && closeIlkS && !inhibitS; // [RULE_06] [RULE_20]

  ////////////////////////////////////////////////////////////////////
  // Command sequencer
  cbcc_pkg::cbcc_state_e state_r, state_nxt;
  logic        swPhase_r, swPhase_nxt;
  logic [15:0] stMs_r;
  logic [15:0] stMsInc;
  logic        msTick;
  logic        openDone, closeDone;

  assign msTick  = tickIf.msTick;
  assign stMsInc = stMs_r + 16'h0001;
  // Pulse ends on length, on inhibit, or on confirmed switching
  assign openDone  = inhibitS || (msTick && stMsInc >= pulseLen_r) // [RULE_07] [RULE_10]
                  || (stMs_r >= `CBCC_HOLD_MIN_MS && openS && !closedS); // [RULE_18]
  assign closeDone = inhibitS || (msTick && stMsInc >= pulseLen_r) // [RULE_07] [RULE_11]
                  || (stMs_r >= `CBCC_HOLD_MIN_MS && closedS && !openS); // [RULE_18]

  // Next state
  always_comb begin
    state_nxt   = state_r;
    swPhase_nxt = swPhase_r;
    case (state_r)
      cbcc_pkg::ST_IDLE: begin
        swPhase_nxt = 1'b0;
        if (openGo) begin
          state_nxt = cbcc_pkg::ST_OPEN;
        end else if (closeGo) begin
          state_nxt = cbcc_pkg::ST_WAIT;
        end
      end
      cbcc_pkg::ST_WAIT: begin
        if (inhibitS || !closeIlkS) begin
          state_nxt = cbcc_pkg::ST_IDLE; // [RULE_07] [RULE_06]
        end else if (syncS) begin
          state_nxt = cbcc_pkg::ST_CLOSE; // [RULE_03] [RULE_20]
        end else if (msTick && !swPhase_r && stMsInc >= synChk_r) begin
          if (synSw_r == 16'h0000) begin
            state_nxt = cbcc_pkg::ST_IDLE; // [RULE_19]
          end else begin
            swPhase_nxt = 1'b1; // [RULE_12]
          end
        end else if (msTick && swPhase_r && stMsInc >= synSw_r) begin
          state_nxt = cbcc_pkg::ST_IDLE;
        end
      end
      cbcc_pkg::ST_OPEN: begin
        if (openDone) begin
          state_nxt = cbcc_pkg::ST_IDLE;
        end
      end
      cbcc_pkg::ST_CLOSE: begin
        if (closeDone) begin
          state_nxt = cbcc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = cbcc_pkg::ST_IDLE;
      end
    endcase
    if (state_nxt == cbcc_pkg::ST_IDLE) begin
      swPhase_nxt = 1'b0;
    end
  end

  // State, phase and per-phase ms count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= cbcc_pkg::ST_IDLE;
      swPhase_r <= 1'b0;
      stMs_r    <= 16'h0000;
    end else begin
      state_r   <= state_nxt;
      swPhase_r <= swPhase_nxt;
      if (state_nxt != state_r || swPhase_nxt != swPhase_r) begin
        stMs_r <= 16'h0000;
      end else if (msTick && stMs_r != 16'hFFFF) begin
        stMs_r <= stMsInc;
      end
    end
  end

  // Outputs follow the next state so they leave flops directly
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      openCommandPulse  <= 1'b0;
      closeCommandPulse <= 1'b0;
      syncSwitchTrigger <= 1'b0;
    end else begin
      openCommandPulse  <= (state_nxt == cbcc_pkg::ST_OPEN); // [RULE_10]
      closeCommandPulse <= (state_nxt == cbcc_pkg::ST_CLOSE); // [RULE_11]
      // A zero wait written mid-phase drops the trigger at once
      syncSwitchTrigger <= (state_nxt == cbcc_pkg::ST_WAIT) && swPhase_nxt
                        && (synSw_r != 16'h0000); // [RULE_12] [RULE_19]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Position filter
  logic [1:0]  pairPrev_r;
  logic [15:0] fltMs_r;
  logic        fltDone, posChange;

  // A new stable value only lands when open and closed disagree
  assign fltDone = msTick && ({openS, closedS} == pairPrev_r)
                && (openS != closedS) && (fltMs_r + 16'h0001 >= filter_r); // [RULE_21]
  // Only a move between two definite positions counts
  assign posChange = fltDone && (positionOpen || positionClosed)
                  && (openS != positionOpen); // [RULE_22]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pairPrev_r     <= 2'b00;
      fltMs_r        <= 16'h0000;
      positionOpen   <= 1'b0;
      positionClosed <= 1'b0;
    end else begin
      pairPrev_r <= {openS, closedS};
      if ({openS, closedS} != pairPrev_r || openS == closedS) begin
        fltMs_r <= 16'h0000; // [RULE_21]
      end else if (msTick && fltMs_r != 16'hFFFF) begin
        fltMs_r <= fltMs_r + 16'h0001;
      end
      if (fltDone) begin
        positionOpen   <= openS; // [RULE_16]
        positionClosed <= closedS; // [RULE_15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operation pulse and unintended switching
  logic [15:0] opMs_r;
  logic        cmdSeen_r, extSeen_r, clrUni;

  assign clrUni = cmdWr && avs_writedata[`CBCC_CMD_CLR_UNI];

  // 150 ms pulse restarted by every operation
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      operationPulse <= 1'b0;
      opMs_r         <= 16'h0000;
    end else if (posChange) begin
      operationPulse <= 1'b1; // [RULE_13]
      opMs_r         <= 16'h0000;
    end else if (operationPulse && msTick) begin
      opMs_r <= opMs_r + 16'h0001;
      if (opMs_r + 16'h0001 >= `CBCC_OPER_MS) begin
        operationPulse <= 1'b0;
      end
    end
  end

  // Evidence of a commanded change, consumed by the next change
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmdSeen_r <= 1'b0;
      extSeen_r <= 1'b0;
    end else begin
      if (openCommandPulse || closeCommandPulse) begin
        cmdSeen_r <= 1'b1;
      end else if (posChange) begin
        cmdSeen_r <= 1'b0;
      end
      if (extS) begin
        extSeen_r <= 1'b1; // [RULE_09]
      end else if (posChange) begin
        extSeen_r <= 1'b0;
      end
    end
  end

  // Flag set wins over software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      unintendedSwitchingFlag <= 1'b0;
    end else if (posChange) begin
      unintendedSwitchingFlag <= !(cmdSeen_r || extSeen_r || extS); // [RULE_14] [RULE_09]
    end else if (clrUni) begin
      unintendedSwitchingFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, loaded as waitrequest drops
  always_comb begin
    rdMux = 32'h0000_0000;
    case (avs_address)
      `CBCC_OFS_PULSE:  rdMux = {16'h0000, pulseLen_r};
      `CBCC_OFS_SYNCHK: rdMux = {16'h0000, synChk_r};
      `CBCC_OFS_SYNSW:  rdMux = {16'h0000, synSw_r};
      `CBCC_OFS_FILTER: rdMux = {16'h0000, filter_r};
      `CBCC_OFS_STATUS: rdMux = {16'h0000, state_r, swPhase_r,
                                 openCommandPulse, closeCommandPulse,
                                 syncSwitchTrigger, operationPulse,
                                 unintendedSwitchingFlag, positionOpen,
                                 positionClosed, pinS[8:3]};
      default:          rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avsWait_r) begin
      avs_readdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_posMove;
    posChange && !(cmdSeen_r || extSeen_r || extS);
  endsequence
  sequence s_flagUp;
    ##1 unintendedSwitchingFlag;
  endsequence

  property p_openPermit;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(openCommandPulse) |-> $past(openIlkS && !inhibitS && (locS || remS));
  endproperty
  a_openPermit: assert property (p_openPermit) // [RULE_05]
    else $error("open pulse without permits");

  property p_closeSync;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(closeCommandPulse) |-> $past(syncS && closeIlkS && !inhibitS);
  endproperty
  a_closeSync: assert property (p_closeSync) // [RULE_03]
    else $error("close pulse without sync or interlock");

  property p_inhibit;
    @(posedge clk_sys) disable iff (!rst_n)
      inhibitS |=> !openCommandPulse && !closeCommandPulse;
  endproperty
  a_inhibit: assert property (p_inhibit) // [RULE_07]
    else $error("command pulse while inhibited");

  property p_pulseEnd;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_r == cbcc_pkg::ST_OPEN) && msTick && stMsInc >= pulseLen_r
      |=> !openCommandPulse;
  endproperty
  a_pulseEnd: assert property (p_pulseEnd) // [RULE_10]
    else $error("open pulse overran its setting");

  property p_minHold;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(closeCommandPulse) |-> $past(inhibitS)
      || $past(stMs_r) >= `CBCC_HOLD_MIN_MS || $past(msTick);
  endproperty
  a_minHold: assert property (p_minHold) // [RULE_18]
    else $error("close pulse withdrawn too early");

  property p_noTrigger;
    @(posedge clk_sys) disable iff (!rst_n)
      (synSw_r == 16'h0000) && $stable(synSw_r) |-> ##1 !syncSwitchTrigger;
  endproperty
  a_noTrigger: assert property (p_noTrigger) // [RULE_19]
    else $error("switch trigger with zero wait");

  property p_operation;
    @(posedge clk_sys) disable iff (!rst_n)
      posChange |=> operationPulse && opMs_r == 16'h0000;
  endproperty
  a_operation: assert property (p_operation) // [RULE_13]
    else $error("operation pulse missing");

  property p_unintended;
    @(posedge clk_sys) disable iff (!rst_n)
      s_posMove |-> s_flagUp;
  endproperty
  a_unintended: assert property (p_unintended) // [RULE_14]
    else $error("unintended change not flagged");

  property p_filterExcl;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(positionOpen) |-> $past(openS != closedS);
  endproperty
  a_filterExcl: assert property (p_filterExcl) // [RULE_21]
    else $error("position taken from ambiguous status");
endmodule

// ---- cbcc_breaker_model.sv ----
// Breaker model: auxiliary contacts driven by the trip and close coils.
// Assumes coil outputs of the control block on clk_sys.
`timescale 1ns/1ps
module cbcc_breaker_model #(
  parameter int unsigned TRAVEL = 600
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic openCoil,
  input  wire logic closeCoil,
  input  wire logic respond,
  input  wire logic kick,
  output logic      openSt,
  output logic      closedSt
);
  logic        posR;
  logic [15:0] travelR;
  ////////////////////////////////////////////////////////////////////////////////
  // Contacts travel for a while; a kick moves the breaker with no coil at all
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      posR    <= 1'b1;
      travelR <= 16'h0000;
    end else if (travelR != 16'h0000) begin
      travelR <= travelR - 16'h0001;
      if (travelR == 16'h0001) posR <= ~posR;
    end else if (kick || (respond && (posR ? openCoil : closeCoil))) begin
      travelR <= TRAVEL[15:0];
    end
  end
  // Both contacts low while moving, as a real breaker shows mid-travel
  assign closedSt = (travelR == 16'h0000) && posR;
  assign openSt   = (travelR == 16'h0000) && !posR;
endmodule

// ---- tb_breaker_command_control.sv ----
// Self-checking bench of the breaker command control block.
// Assumes cbcc_top with a shortened millisecond divider and a breaker model.
`timescale 1ns/1ps
`include "cbcc_consts.svh"
module tb_breaker_command_control;
  localparam int CPM = 20;
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        localPermit, remotePermit, syncPermit, openIlk, closeIlk, inhibit;
  logic        openSt, closedSt, extSeen, respond, kick;
  logic        openCmd, closeCmd, trig, operPulse, unintended, posOpen, posClosed;
  logic [3:0]  mon;
  int          cnt[4], width[4], rises[4];
  int          bad_count, n_tests, cyc;
  cbcc_top #(.CYC_PER_MS(CPM)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .localPermit(localPermit),
    .remotePermit(remotePermit), .syncPermit(syncPermit), .openInterlockPermit(openIlk),
    .closeInterlockPermit(closeIlk), .controlInhibit(inhibit), .breakerOpenStatus(openSt),
    .breakerClosedStatus(closedSt), .externalCommandSeen(extSeen),
    .openCommandPulse(openCmd), .closeCommandPulse(closeCmd), .syncSwitchTrigger(trig),
    .operationPulse(operPulse), .unintendedSwitchingFlag(unintended),
    .positionOpen(posOpen), .positionClosed(posClosed));
  cbcc_breaker_model #(.TRAVEL(30 * CPM)) model_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .openCoil(openCmd), .closeCoil(closeCmd), .respond(respond), .kick(kick),
    .openSt(openSt), .closedSt(closedSt));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling well above the roughly 22000 cycles needed
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      finish_test();
    end
  end
  // Pulse widths in cycles, taken mid-cycle so registered outputs are settled
  always @(negedge clk_sys) begin
    mon = {operPulse, trig, closeCmd, openCmd};
    for (int i = 0; i < 4; i++) begin
      if (mon[i] === 1'b1) cnt[i]++;
      else if (cnt[i] != 0) begin
        width[i] = cnt[i];
        rises[i]++;
        cnt[i] = 0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return {31'h0000_0000, (v >= lo) && (v <= hi)};
  endfunction
  // One Avalon access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic ms(input int n);
    repeat (n * CPM) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Pins in order local, remote, sync, open interlock, close interlock, inhibit
  task automatic pins(input logic [5:0] v);
    @(posedge clk_sys);
    {localPermit, remotePermit, syncPermit, openIlk, closeIlk, inhibit} <= v;
  endtask
  task automatic kickIt;
    @(posedge clk_sys);
    kick <= 1'b1;
    @(posedge clk_sys);
    kick <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdchk(`CBCC_OFS_PULSE, 32'h0000_012C);
    rdchk(`CBCC_OFS_SYNSW, 32'h0000_0000);
    rdchk(5'h18, 32'h0000_0000);
    bus(1'b1, `CBCC_OFS_PULSE, 32'h0000_0031);
    rdchk(`CBCC_OFS_PULSE, 32'h0000_012C);
    bus(1'b1, `CBCC_OFS_PULSE, 32'h0000_03E8);
    rdchk(`CBCC_OFS_PULSE, 32'h0000_03E8);
    bus(1'b1, `CBCC_OFS_SYNCHK, 32'h0000_000A);
    ms(30);
    chk(posClosed, 1'b1);
    chk(posOpen, 1'b0);
    chk(rises[3], 0);
    $display("test regs and settle done");
  endtask
  // Open refused without local permit and without open interlock, then taken and withdrawn early
  task automatic t_open;
    bus(1'b1, `CBCC_OFS_CMD, 32'h0000_0001);
    ms(5);
    chk(openCmd, 1'b0);
    pins(6'b010010);
    bus(1'b1, `CBCC_OFS_CMD, 32'h0000_0004);
    ms(5);
    chk(openCmd, 1'b0);
    pins(6'b011110);
    bus(1'b1, `CBCC_OFS_CMD, 32'h0000_0004);
    ms(2);
    chk(openCmd, 1'b1);
    ms(250);
    chk(rises[0], 1);
    chk(inr(width[0], 1975, 2025), 1);
    chk({posOpen, posClosed}, 2'b10);
    chk(inr(width[3], 2980, 3020), 1);
    chk(unintended, 1'b0);
    $display("test open done");
  endtask
  // Close refused by inhibit, by close interlock, and by missing sync
  task automatic t_close_refused;
    pins(6'b011111);
    bus(1'b1, `CBCC_OFS_CMD, 32'h0000_0008);
    ms(20);
    pins(6'b011100);
    bus(1'b1, `CBCC_OFS_CMD, 32'h0000_0008);
    ms(20);
    chk(rises[1] + closeCmd, 0);
    pins(6'b010110);
    bus(1'b1, `CBCC_OFS_CMD, 32'h0000_0008);
    ms(30);
    chk(rises[1] + closeCmd, 0);
    chk(rises[2] + trig, 0);
    // Idle, breaker open, pins ext 0, closed 0, open 1, inhibit 0, both interlocks 1
    rdchk(`CBCC_OFS_STATUS, 32'h0000_008B);
    chk(q[15:14], 2'b00);
    $display("test close refused done");
  endtask
  // Sync comes late: trigger shown, then a full pulse as the breaker stays put
  task automatic t_switch;
    bus(1'b1, `CBCC_OFS_SYNSW, 32'h0000_0014);
    bus(1'b1, `CBCC_OFS_PULSE, 32'h0000_0032);
    respond <= 1'b0;
    bus(1'b1, `CBCC_OFS_CMD, 32'h0000_0008);
    ms(15);
    chk(trig, 1'b1);
    chk(closeCmd, 1'b0);
    pins(6'b011110);
    ms(70);
    chk(rises[1], 1);
    chk(inr(width[1], 980, 1010), 1);
    chk(rises[2], 1);
    $display("test switch done");
  endtask
  // Moves with and without an external command, then a software clear
  // First move uses up the close pulse; ext is dropped before its move lands
  task automatic t_self;
    @(posedge clk_sys);
    respond <= 1'b1;
    kickIt();
    ms(220);
    chk(unintended, 1'b0);
    @(posedge clk_sys);
    extSeen <= 1'b1;
    kickIt();
    extSeen <= 1'b0;
    ms(220);
    chk(unintended, 1'b0);
    kickIt();
    ms(220);
    chk(unintended, 1'b1);
    chk(rises[3], 4);
    bus(1'b1, `CBCC_OFS_CMD, 32'h0000_0010);
    ms(1);
    chk(unintended, 1'b0);
    $display("test unintended done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Sync permit starts true as with no sync-check present
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {localPermit, remotePermit, syncPermit, openIlk, closeIlk, inhibit} = 6'b001110;
    {extSeen, respond, kick} = 3'b010;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_open();
    t_close_refused();
    t_switch();
    t_self();
    finish_test();
  end
endmodule
